// >>> common/pesf_pkg.sv
/*
 Constants, field layout and event carrier for the primary error status flags.
 Assumes one core clock and a plain register port driven by the configuration master.
*/
// Function
// - Completer Abort completion received sets flag
// - Unsupported Request completion received sets flag
// - Error message sent with enable sets flag
// - Poisoned packet received sets parity flag
// - All flags zero after reset
// - System error flag cleared by writing one
// - Completing with Completer Abort sets flag
package pesf_pkg;
	localparam int ADDR_W = 4;
	// Register indices, word addressed on the plain port
	localparam logic [ADDR_W-1:0] STATUS_ADDR  = 4'h0;
	localparam logic [ADDR_W-1:0] CONTROL_ADDR = 4'h1;
	localparam logic [ADDR_W-1:0] IRQ_ST_ADDR  = 4'h2;
	localparam logic [ADDR_W-1:0] IRQ_MSK_ADDR = 4'h3;
	// Flag positions within the upper status half-word
	localparam int SIG_TABORT_BIT = 27;
	localparam int RCV_TABORT_BIT = 28;
	localparam int RCV_MABORT_BIT = 29;
	localparam int SIG_SERR_BIT   = 30;
	localparam int DET_PERR_BIT   = 31;
	localparam int NUM_EV         = 5;
	localparam logic [NUM_EV-1:0] FLAGS_RST = 5'h00;
	// Flag vector indices, flag word bit minus the lowest flag bit
	localparam int FLAG_LSB       = SIG_TABORT_BIT;
	localparam int SIG_TABORT_IDX = SIG_TABORT_BIT - FLAG_LSB;
	localparam int RCV_TABORT_IDX = RCV_TABORT_BIT - FLAG_LSB;
	localparam int RCV_MABORT_IDX = RCV_MABORT_BIT - FLAG_LSB;
	localparam int SERR_IDX       = SIG_SERR_BIT - FLAG_LSB;
	localparam int DET_PERR_IDX   = DET_PERR_BIT - FLAG_LSB;
	// Control register bit that holds system_error_report_enable
	localparam int SERR_EN_BIT    = 0;
	// Only the system error flag takes write one to clear
	localparam logic [NUM_EV-1:0] W1C_MASK = 5'h01 << SERR_IDX;
	localparam logic [NUM_EV-1:0] RO_MASK  = ~W1C_MASK;
	localparam logic [31:0]       WORD_ZERO = 32'h0000_0000;
	// Events, one-cycle pulses, bit order matches flag order from bit 27 upward
	typedef struct packed {
		logic poisoned_rx;    // Poisoned packet received on primary side
		logic err_msg_tx;     // Fatal or nonfatal error message sent
		logic cpl_ur_rx;      // Completion with Unsupported Request received
		logic cpl_ca_rx;      // Completion with Completer Abort received
		logic ca_sent;        // Request completed with Completer Abort
	} pesf_ev_t;
endpackage

// >>> rtl/pesf_flags.sv
/*
 Primary error status flags with sticky bits, interrupt status and mask.
 Assumes event pulses come from logic on clk; register strobes are one cycle.
 Only the system error flag is software clearable; the rest hold until reset.
 Read data are registered, so software sees the state of the cycle of the strobe.
*/
`timescale 1ns/1ns
module pesf_flags
	import pesf_pkg::*;
(
	input  wire logic              clk,        // Core clock 125 MHz
	input  wire logic              arst_n,     // Async reset, active low
	input  wire pesf_ev_t          ev,         // Event pulses
	input  wire logic [ADDR_W-1:0] addr,       // Register index
	input  wire logic [31:0]       wdata,      // Write data
	input  wire logic              wr,         // Write strobe
	input  wire logic              rd,         // Read strobe
	output logic      [31:0]       rdata,      // Read data, cycle after rd
	output logic                   serr_en,    // Error report enable, from register
	output logic                   irq         // Level interrupt
);
	logic [NUM_EV-1:0] flags_reg;
	logic [NUM_EV-1:0] flags_next;
	logic [NUM_EV-1:0] irq_st_reg;
	logic [NUM_EV-1:0] irq_msk_reg;
	logic              serr_en_reg;
	logic [NUM_EV-1:0] ev_set;
	logic [NUM_EV-1:0] w1c;

	// Refuse package values that the flag layout cannot serve
	if ($bits(pesf_ev_t) != NUM_EV) begin : g_ev_width_chk
		$error("event carrier width differs from flag count");
	end
	if (DET_PERR_BIT - SIG_TABORT_BIT + 1 != NUM_EV) begin : g_flag_span_chk
		$error("flag bits are not one contiguous field");
	end
	if (DET_PERR_BIT >= $bits(WORD_ZERO)) begin : g_flag_top_chk
		$error("flag field does not fit the status word");
	end
	if (SERR_EN_BIT >= $bits(WORD_ZERO)) begin : g_ctrl_bit_chk
		$error("enable bit does not fit the control word");
	end
	if (FLAGS_RST != '0) begin : g_rst_val_chk
		$error("flags must come out of reset at zero");
	end
	if (ADDR_W < 2) begin : g_addr_w_chk
		$error("register index too narrow for four registers");
	end

	// Gate the error message event by the enable bit
	always_comb begin
		ev_set    = ev;
		ev_set[SERR_IDX] = ev.err_msg_tx & serr_en_reg;
	end

	// Only the system error flag is clearable; the others read only
	assign w1c = (wr && addr == STATUS_ADDR && wdata[SIG_SERR_BIT]) ?
		W1C_MASK : FLAGS_RST;

	// Set beats clear so a same-cycle event is never lost
	assign flags_next = (flags_reg & ~w1c) | ev_set;

	// Sticky status flags
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_reg <= FLAGS_RST;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// Control: report enable and interrupt mask
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			serr_en_reg <= 1'b0;
			irq_msk_reg <= FLAGS_RST;
		end else if (wr) begin
			if (addr == CONTROL_ADDR) begin
				serr_en_reg <= wdata[SERR_EN_BIT];
			end
			if (addr == IRQ_MSK_ADDR) begin
				irq_msk_reg <= wdata[NUM_EV-1:0];
			end
		end
	end

	// Interrupt status, write one to clear, set wins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_st_reg <= FLAGS_RST;
		end else if (wr && addr == IRQ_ST_ADDR) begin
			irq_st_reg <= (irq_st_reg & ~wdata[NUM_EV-1:0]) | ev_set;
		end else begin
			irq_st_reg <= irq_st_reg | ev_set;
		end
	end

	// Read data, zero when idle or unmapped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= WORD_ZERO;
		end else if (rd) begin
			unique case (addr)
				STATUS_ADDR:  rdata <= 32'(flags_reg) << FLAG_LSB;
				CONTROL_ADDR: rdata <= 32'(serr_en_reg) << SERR_EN_BIT;
				IRQ_ST_ADDR:  rdata <= 32'(irq_st_reg);
				IRQ_MSK_ADDR: rdata <= 32'(irq_msk_reg);
				default:      rdata <= WORD_ZERO;
			endcase
		end else begin
			rdata <= WORD_ZERO;
		end
	end

	// Register-driven outputs; irq is combinational so a clear drops it at once
	assign serr_en = serr_en_reg;
	assign irq     = |(irq_st_reg & irq_msk_reg);

	// Each event other than the error message sets its own flag one edge later
	sig_tabort_a: assert property (@(posedge clk) disable iff (!arst_n)
		ev.ca_sent |=> flags_reg[SIG_TABORT_IDX])
		else $error("signaled target abort not set");
	rcv_tabort_a: assert property (@(posedge clk) disable iff (!arst_n)
		ev.cpl_ca_rx |=> flags_reg[RCV_TABORT_IDX])
		else $error("received target abort not set");
	rcv_mabort_a: assert property (@(posedge clk) disable iff (!arst_n)
		ev.cpl_ur_rx |=> flags_reg[RCV_MABORT_IDX])
		else $error("received master abort not set");
	perr_set_a: assert property (@(posedge clk) disable iff (!arst_n)
		ev.poisoned_rx |=> flags_reg[DET_PERR_IDX])
		else $error("detected parity error not set");

	// Error message flag follows the report enable
	serr_set_a: assert property (@(posedge clk) disable iff (!arst_n)
		ev.err_msg_tx && serr_en_reg |=> flags_reg[SERR_IDX])
		else $error("signaled system error not set");
	serr_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
		!flags_reg[SERR_IDX] && !(ev.err_msg_tx && serr_en_reg) |=> !flags_reg[SERR_IDX])
		else $error("system error set without enable");

	// System error clear: a one clears, a zero keeps, a same-cycle set wins
	serr_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr && addr == STATUS_ADDR && wdata[SIG_SERR_BIT] && !ev.err_msg_tx |=> !flags_reg[SERR_IDX])
		else $error("system error not cleared");
	serr_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr && addr == STATUS_ADDR && !wdata[SIG_SERR_BIT] && flags_reg[SERR_IDX] |=> flags_reg[SERR_IDX])
		else $error("system error lost on write of zero");
	set_wins_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr && addr == STATUS_ADDR && wdata[SIG_SERR_BIT] && ev.err_msg_tx && serr_en_reg |=> flags_reg[SERR_IDX])
		else $error("system error clear beat its set");

	// Read-only flags never fall until reset
	ro_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
		(flags_reg & RO_MASK) != FLAGS_RST |=> ($past(flags_reg) & RO_MASK & ~flags_reg) == FLAGS_RST)
		else $error("read only flag cleared");

	// Reset leaves flags and outputs at zero, checked at the first edge after release
	rst_zero_a: assert property (@(posedge clk)
		$rose(arst_n) |-> flags_reg == FLAGS_RST)
		else $error("flags not zero after reset");
	rst_out_a: assert property (@(posedge clk)
		$rose(arst_n) |-> rdata == WORD_ZERO && !serr_en && !irq)
		else $error("outputs not zero after reset");

	// Control and mask registers take the written value and keep it otherwise
	ctrl_write_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr && addr == CONTROL_ADDR |=> serr_en == $past(wdata[SERR_EN_BIT]))
		else $error("report enable not written");
	serr_en_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
		!(wr && addr == CONTROL_ADDR) |=> serr_en == $past(serr_en))
		else $error("report enable changed without write");
	mask_write_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr && addr == IRQ_MSK_ADDR |=> irq_msk_reg == $past(wdata[NUM_EV-1:0]))
		else $error("interrupt mask not written");
	mask_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
		!(wr && addr == IRQ_MSK_ADDR) |=> irq_msk_reg == $past(irq_msk_reg))
		else $error("interrupt mask changed without write");

	// Read port: data stand one cycle after the strobe, zero otherwise
	rdata_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
		!rd |=> rdata == WORD_ZERO)
		else $error("read data not zero when idle");
	rdata_status_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd && addr == STATUS_ADDR |=> rdata == (32'($past(flags_reg)) << FLAG_LSB))
		else $error("status read data wrong");
	rdata_ctrl_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd && addr == CONTROL_ADDR |=> rdata == (32'($past(serr_en_reg)) << SERR_EN_BIT))
		else $error("control read data wrong");
	rdata_irq_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd && addr == IRQ_ST_ADDR |=> rdata == 32'($past(irq_st_reg)))
		else $error("interrupt status read data wrong");
	rdata_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd && addr == IRQ_MSK_ADDR |=> rdata == 32'($past(irq_msk_reg)))
		else $error("interrupt mask read data wrong");
	rdata_unmap_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd && addr > IRQ_MSK_ADDR |=> rdata == WORD_ZERO)
		else $error("unmapped read not zero");

	// Per-bit checks of flags and interrupt status
	for (genvar i = 0; i < NUM_EV; i++) begin : g_bit_chk
		// A flag rises only on its own event
		flag_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
			!flags_reg[i] && !ev_set[i] |=> !flags_reg[i])
			else $error("flag set without its event");

		// Interrupt status rises with the event and only then
		irq_set_a: assert property (@(posedge clk) disable iff (!arst_n)
			ev_set[i] |=> irq_st_reg[i])
			else $error("interrupt status not set");
		irq_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
			!irq_st_reg[i] && !ev_set[i] |=> !irq_st_reg[i])
			else $error("interrupt status set without event");

		// Write one clears unless the event lands in the same cycle
		irq_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
			wr && addr == IRQ_ST_ADDR && wdata[i] && !ev_set[i] |=> !irq_st_reg[i])
			else $error("interrupt status not cleared");
		irq_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
			irq_st_reg[i] && !(wr && addr == IRQ_ST_ADDR && wdata[i]) |=> irq_st_reg[i])
			else $error("interrupt status lost");

		// An unmasked status bit raises the level output
		irq_level_a: assert property (@(posedge clk) disable iff (!arst_n)
			irq_st_reg[i] && irq_msk_reg[i] |-> irq)
			else $error("interrupt output low with unmasked status");
	end
endmodule // pesf_flags

// >>> sim/pesf_link_partner.sv
/* Upstream link partner model: sends event pulses.
 Assumes the bench calls send from its main sequence. */
`timescale 1ns/1ns
module pesf_link_partner
	import pesf_pkg::*;
(
	input  wire logic clk, // Core clock
	output pesf_ev_t  ev   // Event pulses
);
	initial ev = '0;
	// One-cycle pulse, bit k in package order
	task automatic send(input int k);
		@(posedge clk) ev <= pesf_ev_t'(5'h01 << k);
		@(posedge clk) ev <= '0;
	endtask
endmodule // pesf_link_partner

// >>> sim/primary_error_status_flags_test.sv
/* Self-checking bench for the primary error status flags.
 Assumes the partner model drives the events. */
`timescale 1ns/1ns
module primary_error_status_flags_test;
	import pesf_pkg::*;
	logic              clk, arst_n, wr, rd, serr_en, irq;
	logic [ADDR_W-1:0] addr;
	logic [31:0]       wdata, rdata;
	pesf_ev_t          ev;
	int                n_fail, n_compared;
	// Row i: status expected after event i, flags accumulate
	logic [31:0] exp_tab [5] = '{32'h0800_0000, 32'h1800_0000, 32'h3800_0000, 32'h7800_0000, 32'hf800_0000};
	pesf_flags i_dut (.clk(clk), .arst_n(arst_n), .ev(ev), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .serr_en(serr_en), .irq(irq));
	pesf_link_partner i_lp (.clk(clk), .ev(ev));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask
	// Read data is looked at only in the cycle after the strobe
	task automatic chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		cmp(rdata, exp);
	endtask
	task automatic print_verdict;
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Sequence needs a few hundred cycles at most
	initial begin
		#20000;
		n_fail++;
		print_verdict();
	end
	initial begin
		{arst_n, wr, rd, addr, wdata} = '0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		chk(STATUS_ADDR, WORD_ZERO);
		i_lp.send(3);
		chk(STATUS_ADDR, WORD_ZERO);
		wr_reg(CONTROL_ADDR, 32'h0000_0001);
		cmp({31'h0, serr_en}, 32'h0000_0001);
		for (int i = 0; i < 5; i++) begin
			i_lp.send(i);
			chk(STATUS_ADDR, exp_tab[i]);
		end
		wr_reg(STATUS_ADDR, WORD_ZERO);
		chk(STATUS_ADDR, 32'hf800_0000);
		wr_reg(STATUS_ADDR, 32'hffff_ffff);
		chk(STATUS_ADDR, 32'hb800_0000);
		// Event and clear in one cycle: the set must win
		fork
			i_lp.send(3);
			wr_reg(STATUS_ADDR, 32'h4000_0000);
		join
		chk(STATUS_ADDR, 32'hf800_0000);
		@(negedge clk) cmp(rdata, WORD_ZERO);
		chk(4'hf, WORD_ZERO);
		cmp({31'h0, irq}, WORD_ZERO);
		wr_reg(IRQ_MSK_ADDR, 32'h0000_001f);
		cmp({31'h0, irq}, 32'h0000_0001);
		wr_reg(IRQ_ST_ADDR, 32'h0000_001f);
		cmp({31'h0, irq}, WORD_ZERO);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		chk(STATUS_ADDR, WORD_ZERO);
		cmp({31'h0, serr_en}, WORD_ZERO);
		print_verdict();
	end
endmodule // primary_error_status_flags_test
